// ===== rtl/handheld_console_unit.sv
// Purpose: console controller core: overlay memory, key capture, I/O commands
// Assumes: bus pins are asynchronous and held stable while their strobe is high
// Notes: memory and I/O requests are taken on edges seen after two-stage sync
`timescale 1ns/1ns
`default_nettype none

module handheld_console_unit #(
   parameter logic [15:0] ROM_IMAGE [256] = '{default: 16'hFFFF}
) (
   input  wire logic        clock,          // system clock, 10 MHz
   input  wire logic        rstn,           // synchronous reset, active low
   input  wire logic        mem_start,      // memory cycle strobe, high during cycle
   input  wire logic [14:0] mem_addr,       // word address
   input  wire logic [1:0]  mem_op,         // console_pkg::OP_* code
   input  wire logic [15:0] mem_data_in,    // data bus as seen on the pins
   output logic      [15:0] mem_data_out,   // read word toward the bus
   output logic             mem_data_oen,   // low while driving the data bus
   output logic             ram_inhibit,    // keeps other memory off the bus
   input  wire logic        io_clk,         // I/O bus clock, sampled
   input  wire logic        io_sel,         // command addressed to this unit
   input  wire logic [1:0]  io_func,        // console_pkg::FUNC_* code
   input  wire logic [1:0]  io_flag,        // console_pkg::FLAG_* code
   output logic      [15:0] io_rdata,       // input lines to io_port_controller
   output logic             io_rdata_valid, // one-cycle pulse with io_rdata
   output logic             busy,           // busy flag
   output logic             done,           // done flag
   output logic             irq,            // program interrupt request
   input  wire logic        key_strobe,     // a key in the driven row is down
   input  wire logic [1:0]  key_col,        // encoded column of that key
   output logic      [5:0]  digit_en,       // digit cells, also key rows
   output logic      [6:0]  segments        // segment drive
);
   import console_pkg::*;

   localparam int PIN_W = 43;

   typedef enum logic [1:0] {MEM_IDLE, MEM_SERVE, MEM_SKIP} mem_state_t;

   typedef struct packed {
      logic [PIN_W-1:0]  sync1;
      logic [PIN_W-1:0]  sync2;
      logic              start_d;
      logic              io_clk_d;
      mem_state_t        state;
      logic [1:0]        op;
      logic [7:0]        low;
      logic [15:0][15:0] ram;
      logic [15:0]       data_out;
      logic              data_oen;
      logic              inhibit;
      logic [15:0]       disp_word;
      logic              seen;
      logic [4:0]        seen_code;
      logic [4:0]        last_code;
      logic [1:0]        stable;
      logic              reported;
      logic [4:0]        key_code;
      logic              busy;
      logic              done;
      logic              irq;
      logic [15:0]       io_rdata;
      logic              io_rdata_valid;
   } core_state_t;

   core_state_t s;
   core_state_t next_s;
   console_if   scan_link ();

   logic [PIN_W-1:0] pins;
   logic             p_start;
   logic [14:0]      p_addr;
   logic [1:0]       p_op;
   logic [15:0]      p_data;
   logic             p_io_clk;
   logic             p_io_sel;
   logic [1:0]       p_func;
   logic [1:0]       p_flag;
   logic             p_strobe;
   logic [1:0]       p_col;
   logic [4:0]       row_code;

   assign pins = {mem_start, mem_addr, mem_op, mem_data_in, io_clk, io_sel,
                  io_func, io_flag, key_strobe, key_col};
   assign {p_start, p_addr, p_op, p_data, p_io_clk, p_io_sel,
           p_func, p_flag, p_strobe, p_col} = s.sync2;

   function automatic logic [15:0] read_word(input logic [15:0][15:0] ram_q,
                                             input logic [7:0]        a);
      logic        in_ovl;
      logic [15:0] rom;
      in_ovl = (a >= OVERLAY_LO) && (a <= OVERLAY_HI);  // R3
      rom = in_ovl ? ALL_ONES : ROM_IMAGE[a];  // R2 R4
      return in_ovl ? (rom & ram_q[a[3:0]]) : rom;  // R3 R4
   endfunction

   always_comb begin
      next_s = s;
      row_code = {scan_link.ended_step, p_col};
      next_s.sync1 = pins;
      next_s.sync2 = s.sync1;
      next_s.start_d = p_start;
      next_s.io_clk_d = p_io_clk;
      next_s.io_rdata_valid = 1'b0;

      ////////////////////////////////////////////////////////////////////////
      // memory bus slave
      case (s.state)
         MEM_IDLE: begin
            if (p_start && !s.start_d) begin
               if (p_addr > CLAIM_FLOOR && p_op != OP_REFRESH) begin  // R1 R8
                  next_s.state = MEM_SERVE;
                  next_s.op = p_op;
                  next_s.low = p_addr[7:0];  // R1
                  if (p_op != OP_WRITE) begin
                     next_s.data_out = read_word(s.ram, p_addr[7:0]);
                     next_s.data_oen = 1'b0;
                     next_s.inhibit = 1'b1;  // R5 R6
                  end
               end else begin
                  next_s.state = MEM_SKIP;
               end
            end else if (scan_link.step_tick) begin
               next_s.disp_word = read_word(s.ram, DISPLAY_LOC);  // R9
            end
         end
         MEM_SERVE: begin
            if (!p_start) begin
               next_s.state = MEM_IDLE;
               next_s.data_oen = 1'b1;
               next_s.inhibit = 1'b0;
               if (s.op != OP_READ && s.low >= OVERLAY_LO
                   && s.low <= OVERLAY_HI) begin
                  next_s.ram[s.low[3:0]] = p_data;  // R7
               end
            end
         end
         MEM_SKIP: begin
            if (!p_start) begin
               next_s.state = MEM_IDLE;
            end
         end
         default: begin
            next_s.state = MEM_IDLE;
         end
      endcase

      ////////////////////////////////////////////////////////////////////////
      // key scan and debounce, judged once per full scan frame
      if (scan_link.step_tick) begin
         if (p_strobe && scan_link.ended_step <= LAST_KEY_ROW && !s.seen) begin
            next_s.seen = 1'b1;  // R12
            next_s.seen_code = row_code;
         end
         if (scan_link.ended_step == LAST_STEP) begin
            next_s.seen = 1'b0;
            if (!s.seen) begin
               next_s.stable = 2'h0;
               next_s.reported = 1'b0;
            end else if (s.stable == 2'h0 || s.seen_code != s.last_code) begin
               next_s.stable = 2'h1;
               next_s.last_code = s.seen_code;
               next_s.reported = 1'b0;
            end else if (s.stable != DEBOUNCE_FRAMES) begin
               next_s.stable = s.stable + 2'h1;  // R19
            end
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // I/O commands on rising io_clk edges
      if (p_io_clk && !s.io_clk_d && p_io_sel) begin
         if (p_func == FUNC_READ_SWITCH) begin
            next_s.io_rdata = read_word(s.ram, SWITCHES_LOC);  // R16
            next_s.io_rdata_valid = 1'b1;
         end else if (p_func == FUNC_READ_KEY) begin
            next_s.io_rdata = 16'h0000;  // R17
            next_s.io_rdata[KEY_CODE_LSB +: 5] = s.key_code;  // R15 R17
            next_s.io_rdata_valid = 1'b1;
         end
         if (p_flag == FLAG_S) begin
            next_s.busy = 1'b1;  // R18
            next_s.done = 1'b0;
         end else if (p_flag == FLAG_C) begin
            next_s.busy = 1'b0;  // R18
            next_s.done = 1'b0;
         end else if (p_flag == FLAG_P) begin
            next_s.done = 1'b0;  // R18
         end
      end

      // capture after the flag commands so a new key beats a clear
      if (s.stable == DEBOUNCE_FRAMES && !s.reported) begin
         next_s.reported = 1'b1;
         next_s.key_code = s.last_code;  // R13
         next_s.busy = 1'b0;
         next_s.done = 1'b1;  // R14
      end
      next_s.irq = next_s.done;  // R14
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         s <= '{state: MEM_IDLE, data_oen: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign scan_link.word = s.disp_word;

   display_scan u_scan (
      .clock    (clock),
      .rstn     (rstn),
      .link     (scan_link),
      .digit_en (digit_en),
      .segments (segments)
   );

   assign mem_data_out = s.data_out;
   assign mem_data_oen = s.data_oen;
   assign ram_inhibit = s.inhibit;
   assign io_rdata = s.io_rdata;
   assign io_rdata_valid = s.io_rdata_valid;
   assign busy = s.busy;
   assign done = s.done;
   assign irq = s.irq;
endmodule // handheld_console_unit

`default_nettype wire

// ===== shared/console_pkg.sv
// Purpose: constants and lookup tables shared by the console controller modules
// Assumes: 10 MHz clock, 15-bit word address on the memory bus
// Notes: word bit 15 is the bus's bit 0 (most significant first numbering)
// Notes on behaviour
// R1: claim a memory cycle above 077377 octal; latch the low 8 address bits.
// R2: memory is 256 read-only words of 16 bits plus a 16-word writable overlay.
// R3: low byte 160..177 octal also enables overlay; low 4 bits pick its word.
// R4: read-only words under the overlay are all ones; reads AND both words.
// R5: assert ram_inhibit while the read word is driven onto the bus.
// R6: other system memory at 077400..077777 stays silent while ram_inhibit is high.
// R7: writes update storage only inside the overlay; other claimed writes vanish.
// R8: refresh cycles are ignored entirely.
// R9: display word at 77576 octal is fetched locally, only while the bus is idle.
// R10: six-step scanner picks one 3-bit nibble per step and its digit cell.
// R11: step number and nibble are latched each step; one cell lit, nibble decoded.
// R12: 4 columns by 5 rows; rows follow the scanner; columns arrive as 2-bit code.
// R13: debounced key strobe captures step and column into the 5-bit key code.
// R14: a captured key raises the program interrupt request.
// R15: read_key_code_cmd places the key code on the controller input lines.
// R16: commands decode from function codes; one moves a memory word to the input path.
// R17: key code sits in bits 3-7, bits 0-2 read zero, the rest unspecified.
// R18: S sets busy and clears done, C clears both, P clears done only.
// R19: key strobe must stay stable for DEBOUNCE_FRAMES scan frames before capture.

package console_pkg;
   localparam int          CLK_PERIOD_NS     = 100;
   localparam int          SCAN_STEP_NS      = 400000;
   localparam int          SCAN_STEP_CYCLES  = SCAN_STEP_NS / CLK_PERIOD_NS;
   localparam logic [2:0]  LAST_STEP         = 3'h5;
   localparam logic [2:0]  LAST_KEY_ROW      = 3'h4;
   localparam logic [1:0]  DEBOUNCE_FRAMES   = 2'h3;
   localparam logic [14:0] CLAIM_FLOOR       = 15'h7EFF;
   localparam logic [7:0]  OVERLAY_LO        = 8'h70;
   localparam logic [7:0]  OVERLAY_HI        = 8'h7F;
   localparam logic [7:0]  DISPLAY_LOC       = 8'h7E;
   localparam logic [7:0]  SWITCHES_LOC      = 8'h7F;
   localparam logic [1:0]  OP_READ           = 2'h0;
   localparam logic [1:0]  OP_WRITE          = 2'h1;
   localparam logic [1:0]  OP_RMW            = 2'h2;
   localparam logic [1:0]  OP_REFRESH        = 2'h3;
   localparam logic [1:0]  FUNC_NONE         = 2'h0;
   localparam logic [1:0]  FUNC_READ_SWITCH  = 2'h1;
   localparam logic [1:0]  FUNC_READ_KEY     = 2'h2;
   localparam logic [1:0]  FLAG_NONE         = 2'h0;
   localparam logic [1:0]  FLAG_S            = 2'h1;
   localparam logic [1:0]  FLAG_C            = 2'h2;
   localparam logic [1:0]  FLAG_P            = 2'h3;
   localparam int          KEY_CODE_LSB      = 8;
   localparam logic [15:0] ALL_ONES          = 16'hFFFF;
   // segments g..a, active high
   localparam logic [6:0]  SEG_TABLE [8] = '{7'h3F, 7'h06, 7'h5B, 7'h4F,
                                             7'h66, 7'h6D, 7'h7D, 7'h07};
endpackage

// ===== shared/console_if.sv
// Purpose: carries the scan position and display word between core and scanner
// Assumes: single clock domain
// Notes: step_tick is a one-cycle pulse with ended_step valid alongside it
`timescale 1ns/1ns
`default_nettype none

interface console_if;
   logic [15:0] word;
   logic [2:0]  ended_step;
   logic        step_tick;
   modport scan (input word, output ended_step, output step_tick);
   modport core (output word, input ended_step, input step_tick);
endinterface // console_if

`default_nettype wire

// ===== rtl/display_scan.sv
// Purpose: six-step display scanner and octal to seven-segment driver
// Assumes: word from the core is stable between step ticks
// Notes: digit cell 0 is the left-hand digit, showing word bit 15 alone
`timescale 1ns/1ns
`default_nettype none

module display_scan (
   input  wire logic       clock,     // system clock
   input  wire logic       rstn,      // synchronous reset, active low
   console_if.scan         link,      // scan position and display word
   output logic      [5:0] digit_en,  // one-hot digit cell enable
   output logic      [6:0] segments   // lit segments of the enabled cell
);
   import console_pkg::*;

   typedef struct packed {
      logic [11:0] div;
      logic [2:0]  shown;
      logic [2:0]  ended;
      logic        tick;
      logic [5:0]  digit_en;
      logic [6:0]  segments;
   } scan_state_t;

   scan_state_t s;
   scan_state_t next_s;
   logic [17:0] wide_word;
   logic [17:0] shifted;
   logic [2:0]  next_step;

   assign wide_word = {2'h0, link.word};

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      next_step = (s.shown == LAST_STEP) ? 3'h0 : s.shown + 3'h1;  // R10
      shifted = wide_word >> (3 * (LAST_STEP - next_step));
      if (s.div == 12'(SCAN_STEP_CYCLES - 1)) begin
         next_s.div = 12'h000;
         next_s.tick = 1'b1;
         next_s.ended = s.shown;
         next_s.shown = next_step;
         next_s.digit_en = 6'h01 << next_step;  // R11
         next_s.segments = SEG_TABLE[shifted[2:0]];  // R10 R11
      end else begin
         next_s.div = s.div + 12'h001;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign link.ended_step = s.ended;
   assign link.step_tick = s.tick;
   assign digit_en = s.digit_en;
   assign segments = s.segments;
endmodule // display_scan

`default_nettype wire

// ===== verification/console_assertions.sv
// Purpose: port-level checks of the console controller
// Assumes: single clock domain, bench keeps the bus spacing rules
// Notes: bound from the testbench file
`timescale 1ns/1ns
`default_nettype none

module console_assertions
   import console_pkg::*;
(
   input wire logic        clock,          // system clock
   input wire logic        rstn,           // sync reset, low
   input wire logic        mem_start,      // cycle strobe
   input wire logic [14:0] mem_addr,       // word address
   input wire logic [1:0]  mem_op,         // cycle kind
   input wire logic        mem_data_oen,   // drive, low active
   input wire logic        ram_inhibit,    // claim flag
   input wire logic        io_clk,         // I/O clock
   input wire logic        io_sel,         // unit select
   input wire logic [1:0]  io_func,        // transfer code
   input wire logic [1:0]  io_flag,        // flag command
   input wire logic [15:0] io_rdata,       // answer word
   input wire logic        io_rdata_valid, // answer pulse
   input wire logic        busy,           // busy flag
   input wire logic        done,           // done flag
   input wire logic        irq,            // interrupt
   input wire logic [5:0]  digit_en        // digit cells
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////
   inhibit_with_drive_a: assert property (ram_inhibit == !mem_data_oen)
      else $error("ram_inhibit and data drive disagree");
   read_answer_a: assert property ($rose(mem_start) && mem_addr > CLAIM_FLOOR &&
      mem_op == OP_READ |-> ##2 !ram_inhibit ##1 ram_inhibit) else $error("claimed read late");
   below_floor_a: assert property ($rose(mem_start) && mem_addr <= CLAIM_FLOOR
      |-> ##1 !ram_inhibit [*6]) else $error("unclaimed address answered");
   refresh_quiet_a: assert property ($rose(mem_start) && mem_op == OP_REFRESH
      |-> ##1 !ram_inhibit [*6]) else $error("refresh answered");
   drive_release_a: assert property ($fell(mem_start) && ram_inhibit
      |-> ##2 ram_inhibit ##1 !ram_inhibit) else $error("bus release timing wrong");
   io_pulse_a: assert property (io_rdata_valid |=> !io_rdata_valid)
      else $error("answer pulse too long");
   io_answer_a: assert property ($rose(io_clk) && io_sel && io_func != FUNC_NONE
      |-> ##2 !io_rdata_valid ##1 io_rdata_valid) else $error("answer timing wrong");
   key_format_a: assert property (io_rdata_valid && $past(io_func, 3) == FUNC_READ_KEY
      |-> io_rdata[7:0] == 8'h00 && io_rdata[15:13] == 3'h0) else $error("key word layout");
   flag_set_a: assert property ($rose(io_clk) && io_sel && io_flag == FLAG_S
      |-> ##3 busy && !done) else $error("set command wrong");
   flag_clear_a: assert property ($rose(io_clk) && io_sel && io_flag == FLAG_C
      |-> ##3 !busy && !done) else $error("clear command wrong");
   irq_follows_a: assert property (irq == done)
      else $error("interrupt not tied to done");
   one_cell_a: assert property (digit_en != 6'h00 |-> $onehot(digit_en))
      else $error("more than one digit lit");
endmodule // console_assertions

`default_nettype wire

// ===== verification/host_model.sv
// Purpose: processor side of the memory and I/O buses
// Assumes: requests launched at the falling clock edge
// Notes: released bus lines show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none

module host_model
   import console_pkg::*;
(
   input  wire logic        clock,          // system clock
   output logic             mem_start,      // cycle strobe
   output logic      [14:0] mem_addr,       // word address
   output logic      [1:0]  mem_op,         // cycle kind
   output logic      [15:0] mem_data_in,    // resolved data bus
   input  wire logic [15:0] mem_data_out,   // console word
   input  wire logic        mem_data_oen,   // console drive, low
   input  wire logic        ram_inhibit,    // console claim
   output logic             io_clk,         // I/O clock
   output logic             io_sel,         // unit select
   output logic      [1:0]  io_func,        // transfer code
   output logic      [1:0]  io_flag,        // flag command
   input  wire logic [15:0] io_rdata,       // answer word
   input  wire logic        io_rdata_valid  // answer pulse
);
   logic [15:0] drv = 16'hA5A5;
   // other memory stays off the bus while the console drives
   assign mem_data_in = mem_data_oen ? drv : mem_data_out;
   initial begin
      mem_start = 1'b0;
      mem_addr = 15'h0000;
      mem_op = OP_READ;
      {io_clk, io_sel, io_func, io_flag} = 6'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic mem_cycle(input logic [14:0] a, input logic [1:0] op, input logic [15:0] wd,
                            output logic [15:0] rd, output logic hit);
      hit = 1'b0;
      rd = 16'h0000;
      @(negedge clock);
      mem_addr = a;
      mem_op = op;
      mem_start = 1'b1;
      if (op == OP_WRITE) drv = wd;
      for (int i = 0; i < 8 && !hit; i++) begin
         @(negedge clock);
         if (ram_inhibit === 1'b1) begin
            hit = 1'b1;
            rd = mem_data_out;
         end
      end
      @(negedge clock);
      mem_start = 1'b0;
      repeat (4) @(negedge clock);
      drv = ~drv;
   endtask
   task automatic io_cmd(input logic sel, input logic [1:0] fn, input logic [1:0] fl,
                         output logic [15:0] rd);
      rd = 16'hDEAD;
      @(negedge clock);
      io_sel = sel;
      io_func = fn;
      io_flag = fl;
      repeat (4) @(negedge clock);
      io_clk = 1'b1;
      repeat (4) begin
         @(negedge clock);
         if (io_rdata_valid === 1'b1) rd = io_rdata;
      end
      io_clk = 1'b0;
      repeat (4) @(negedge clock);
      io_sel = 1'b0;
   endtask
endmodule // host_model

`default_nettype wire

// ===== verification/testbench.sv
// Purpose: self-checking bench of the console controller
// Assumes: key held down from reset until captured
// Notes: one key capture takes a few scan frames
`timescale 1ns/1ns
`default_nettype none

module testbench;
   import console_pkg::*;
   typedef logic [15:0] rom_t [256];
   function automatic rom_t make_rom();
      rom_t r;
      for (int a = 0; a < 256; a++) begin
         r[a] = (a >= 8'h70 && a <= 8'h7F) ? ALL_ONES : {8'hC3 ^ a[7:0], a[7:0]};
      end
      return r;
   endfunction
   localparam rom_t ROM = make_rom();
   logic clock, rstn, mem_start, mem_data_oen, ram_inhibit, io_clk, io_sel, io_rdata_valid;
   logic busy, done, irq, press;
   logic key_strobe = 1'b0;
   logic [1:0] key_col = 2'h0, kcol, mem_op, io_func, io_flag;
   logic [14:0] mem_addr;
   logic [15:0] mem_data_in, mem_data_out, io_rdata, rd;
   logic [15:0] ram [16] = '{default: 16'h0000};
   logic [5:0] digit_en;
   logic [6:0] segments;
   int seed = 32'hFDC5, fail_count = 0, samples_checked = 0;
   ////////////////////////////////////////////////////////////////////////
   handheld_console_unit #(.ROM_IMAGE(ROM)) u_handheld_console_unit (.clock, .rstn,
      .mem_start, .mem_addr, .mem_op, .mem_data_in, .mem_data_out, .mem_data_oen,
      .ram_inhibit, .io_clk, .io_sel, .io_func, .io_flag, .io_rdata, .io_rdata_valid,
      .busy, .done, .irq, .key_strobe, .key_col, .digit_en, .segments);
   host_model u_host_model (.clock, .mem_start, .mem_addr, .mem_op, .mem_data_in,
      .mem_data_out, .mem_data_oen, .ram_inhibit, .io_clk, .io_sel, .io_func, .io_flag,
      .io_rdata, .io_rdata_valid);
   function automatic logic [15:0] exp_read(input logic [7:0] a);
      if (a >= OVERLAY_LO && a <= OVERLAY_HI) return ROM[a] & ram[a[3:0]];
      return ROM[a];
   endfunction
   function automatic logic [15:0] seg_for(input logic [15:0] w, input logic [5:0] en);
      int k;
      logic [2:0] nib;
      k = 0;
      for (int j = 0; j < 6; j++) begin
         if (en[j]) k = j;
      end
      nib = (k == 0) ? {2'h0, w[15]} : w[17 - 3 * k -: 3];
      return {9'h000, SEG_TABLE[nib]};
   endfunction
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // key of row 3 held while its row is driven
   always @(negedge clock) begin
      key_strobe <= press && digit_en === 6'h08;
      key_col <= kcol;
   end
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   initial begin
      repeat (98000) @(posedge clock);
      fail_count++;
      finish_test();
   end
   initial begin
      logic [7:0] a;
      logic [15:0] d;
      logic [5:0] last;
      logic hit;
      rstn = 1'b0;
      kcol = 2'($random(seed));
      press = 1'b0;
      repeat (4) @(negedge clock);
      check("reset outputs", {10'h0, mem_data_oen, ram_inhibit, io_rdata_valid, busy, done, irq},
            16'h0020);
      rstn = 1'b1;
      press = 1'b1;
      for (int i = 0; i < 28; i++) begin
         a = (i < 16) ? 8'h70 + 8'(i) : 8'($random(seed));
         d = 16'($random(seed));
         u_host_model.mem_cycle({7'h7F, a}, OP_WRITE, d, rd, hit);
         if (a >= OVERLAY_LO && a <= OVERLAY_HI) ram[a[3:0]] = d;
         u_host_model.mem_cycle({7'h7F, a}, i[0] ? OP_RMW : OP_READ, 16'h0000, rd, hit);
         check("read claim", {15'h0, hit}, 16'h0001);
         check("read word", rd, exp_read(a));
      end
      u_host_model.mem_cycle(15'h7EFF, OP_READ, 16'h0000, rd, hit);
      check("floor claim", {15'h0, hit}, 16'h0000);
      u_host_model.mem_cycle(15'h7F00, OP_READ, 16'h0000, rd, hit);
      check("lowest claim", {15'h0, hit}, 16'h0001);
      u_host_model.mem_cycle(15'h7F70, OP_REFRESH, 16'h0000, rd, hit);
      check("refresh claim", {15'h0, hit}, 16'h0000);
      for (int n = 0; n < 7; n++) begin
         last = digit_en;
         while (digit_en === last) @(negedge clock);
         repeat (2) @(negedge clock);
         if (n > 0) check("segments", {9'h000, segments}, seg_for(ram[14], digit_en));
      end
      // only one full frame has seen the key so far
      check("early capture", {15'h0, done}, 16'h0000);
      for (int i = 0; i < 80000 && done !== 1'b1; i++) @(negedge clock);
      press = 1'b0;
      check("capture", {13'h0, busy, done, irq}, 16'h0003);
      u_host_model.io_cmd(1'b1, FUNC_READ_KEY, FLAG_P, rd);
      check("key code", rd, {3'h0, 3'h3, kcol, 8'h00});
      check("flags p", {14'h0, busy, done}, 16'h0000);
      u_host_model.io_cmd(1'b1, FUNC_NONE, FLAG_S, rd);
      check("flags s", {14'h0, busy, done}, 16'h0002);
      u_host_model.io_cmd(1'b0, FUNC_NONE, FLAG_C, rd);
      check("deselected", {14'h0, busy, done}, 16'h0002);
      u_host_model.io_cmd(1'b1, FUNC_READ_SWITCH, FLAG_C, rd);
      check("switch word", rd, ram[15]);
      check("flags c", {14'h0, busy, done}, 16'h0000);
      finish_test();
   end
endmodule // testbench

bind handheld_console_unit console_assertions u_console_assertions (.clock, .rstn,
   .mem_start, .mem_addr, .mem_op, .mem_data_oen, .ram_inhibit, .io_clk, .io_sel,
   .io_func, .io_flag, .io_rdata, .io_rdata_valid, .busy, .done, .irq, .digit_en);

`default_nettype wire
